// [epis_pkg.sv]
// constants and register map of the external pin interrupt sense block
// ****************************************************************
// ****************************************************************
`default_nettype none
package epis_pkg;
    // apb byte addresses
    localparam logic [11:0] ADDR_CORE_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_ENABLE     = 12'h004;
    localparam logic [11:0] ADDR_FLAG       = 12'h008;
    localparam logic [11:0] ADDR_STATUS     = 12'h00c;
    // field positions
    localparam int SENSE_A_LSB   = 0;
    localparam int SENSE_B_LSB   = 2;
    localparam int BIT_EN_B      = 7;
    localparam int BIT_EN_A      = 6;
    localparam int BIT_VEC_SEL   = 1;
    localparam int BIT_VEC_UNLK  = 0;
    localparam int BIT_FLAG_B    = 7;
    localparam int BIT_FLAG_A    = 6;
    localparam logic [7:0] ENABLE_RW_MASK = 8'hc3;
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    // sense encodings
    typedef enum logic [1:0] {
        EPIS_LOW     = 2'h0,
        EPIS_CHANGE  = 2'h1,
        EPIS_FALL    = 2'h2,
        EPIS_RISE    = 2'h3
    } epis_sense_t;
    // watchdog clock period and the sample count for wake
    localparam int WDT_PERIOD_NS    = 1000;
    localparam int CLK_PERIOD_NS    = 5;
    localparam int WAKE_SAMPLES     = 2;
    localparam int STARTUP_CYC_DEF  = 64;
endpackage : epis_pkg
`default_nettype wire

// [epis_sense.sv]
// one pin: synchroniser, edge detect and sense select
`timescale 1ns/1ps
`default_nettype none
module epis_sense (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // io clock running
    input  wire logic       io_clk_run,
    // pin and mode
    input  wire logic       pin_in,
    input  wire logic [1:0] sense,
    // result
    output logic            edge_evt,
    output logic            level_low
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;

    // ****************************************************************
    // sampling
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    wire rise_w   = sync2_r & ~prev_r;
    wire fall_w   = ~sync2_r & prev_r;
    wire change_w = sync2_r ^ prev_r;
    wire sel_w    = (sense == epis_pkg::EPIS_CHANGE) ? change_w :
                    (sense == epis_pkg::EPIS_FALL)   ? fall_w   :
                    (sense == epis_pkg::EPIS_RISE)   ? rise_w   : 1'b0;
    // edges only while io clock runs
    assign edge_evt  = sel_w & io_clk_run;
    // raw pin, no clock needed; lets a stopped clock still see it
    assign level_low = (sense == epis_pkg::EPIS_LOW) & ~pin_in;
endmodule : epis_sense
`default_nettype wire

// [epis_wake.sv]
// power-down wake qualifier driven by watchdog tick
`timescale 1ns/1ps
`default_nettype none
module epis_wake #(
    parameter int STARTUP_CYC = epis_pkg::STARTUP_CYC_DEF
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // power state and watchdog tick
    input  wire logic power_down,
    input  wire logic wdt_tick,
    input  wire logic level_req,
    // outputs
    output logic      wake_req,
    output logic      startup_busy,
    output logic      level_kept
);
    typedef enum logic [1:0] { WK_IDLE, WK_SAMPLE, WK_START } epis_wk_t;
    epis_wk_t   st_r;
    logic [1:0] samp_r;
    logic [15:0] cnt_r;
    logic       wake_r;
    logic       kept_r;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r   <= WK_IDLE;
            samp_r <= 2'h0;
            cnt_r  <= 16'h0000;
            wake_r <= 1'b0;
            kept_r <= 1'b0;
        end else begin
            wake_r <= 1'b0;
            kept_r <= 1'b0;
            unique case (st_r)
                WK_IDLE: begin
                    samp_r <= 2'h0;
                    if (power_down && level_req) st_r <= WK_SAMPLE;
                end
                WK_SAMPLE: begin
                    if (!level_req || !power_down) begin
                        st_r <= WK_IDLE;
                    end else if (wdt_tick) begin
                        if (samp_r == 2'(epis_pkg::WAKE_SAMPLES - 1)) begin
                            st_r   <= WK_START;
                            wake_r <= 1'b1;
                            cnt_r  <= 16'(STARTUP_CYC);
                        end else begin
                            samp_r <= samp_r + 2'h1;
                        end
                    end
                end
                WK_START: begin
                    if (cnt_r == 16'h0001) begin
                        st_r   <= WK_IDLE;
                        kept_r <= level_req;
                    end
                    cnt_r <= cnt_r - 16'h0001;
                end
                default: st_r <= WK_IDLE;
            endcase
        end
    end
    assign wake_req     = wake_r;
    assign startup_busy = (st_r == WK_START);
    assign level_kept   = kept_r;
endmodule : epis_wake
`default_nettype wire

// [epis_top.sv]
// external pin interrupt sense with apb registers
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module epis_top #(
    parameter int STARTUP_CYC = epis_pkg::STARTUP_CYC_DEF
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins and core status
    input  wire logic        ext_irq_pin_a,
    input  wire logic        ext_irq_pin_b,
    input  wire logic        global_irq_en,
    input  wire logic        io_clk_run,
    input  wire logic        power_down,
    input  wire logic        wdt_tick,
    // vector acknowledge from core
    input  wire logic        vec_ack_a,
    input  wire logic        vec_ack_b,
    // requests to core
    output logic             irq_req_a,
    output logic             irq_req_b,
    output logic             wake_req,
    output logic             vector_table_select,
    output logic             vector_change_unlock
);
    logic [7:0] core_control_reg_r;
    logic [7:0] irq_enable_control_reg_r;
    logic       pending_flag_a_r;
    logic       pending_flag_b_r;
    logic [31:0] prdata_r;
    logic       evt_a;
    logic       evt_b;
    logic       low_a;
    logic       low_b;
    logic       startup_busy;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire acc_w    = psel & penable;
    wire wr_w     = acc_w & pwrite;
    wire hit_core = (paddr == epis_pkg::ADDR_CORE_CTRL);
    wire hit_en   = (paddr == epis_pkg::ADDR_ENABLE);
    wire hit_flag = (paddr == epis_pkg::ADDR_FLAG);
    wire hit_stat = (paddr == epis_pkg::ADDR_STATUS);
    wire mapped_w = hit_core | hit_en | hit_flag | hit_stat;
    assign pready  = 1'b1;
    assign pslverr = acc_w & ~mapped_w;

    wire [1:0] sense_a = core_control_reg_r[epis_pkg::SENSE_A_LSB +: 2];
    wire [1:0] sense_b = core_control_reg_r[epis_pkg::SENSE_B_LSB +: 2];
    wire en_a  = irq_enable_control_reg_r[epis_pkg::BIT_EN_A] & global_irq_en;
    wire en_b  = irq_enable_control_reg_r[epis_pkg::BIT_EN_B] & global_irq_en;
    wire lvl_a = (sense_a == epis_pkg::EPIS_LOW);
    wire lvl_b = (sense_b == epis_pkg::EPIS_LOW);
    wire clr_a = (wr_w & hit_flag & pwdata[epis_pkg::BIT_FLAG_A]) | vec_ack_a;
    wire clr_b = (wr_w & hit_flag & pwdata[epis_pkg::BIT_FLAG_B]) | vec_ack_b;

    // ****************************************************************
    // pin sense
    // ****************************************************************
    epis_sense u_sense_a (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .io_clk_run (io_clk_run),
        .pin_in     (ext_irq_pin_a),
        .sense      (sense_a),
        .edge_evt   (evt_a),
        .level_low  (low_a)
    );
    epis_sense u_sense_b (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .io_clk_run (io_clk_run),
        .pin_in     (ext_irq_pin_b),
        .sense      (sense_b),
        .edge_evt   (evt_b),
        .level_low  (low_b)
    );

    // ****************************************************************
    // wake from power-down
    // ****************************************************************
    epis_wake #(
        .STARTUP_CYC (STARTUP_CYC)
    ) u_wake (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .power_down   (power_down),
        .wdt_tick     (wdt_tick),
        .level_req    ((low_a & en_a) | (low_b & en_b)),
        .wake_req     (wake_req),
        .startup_busy (startup_busy),
        .level_kept   ()
    );

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            core_control_reg_r       <= epis_pkg::RESET_BYTE;
            irq_enable_control_reg_r <= epis_pkg::RESET_BYTE;
        end else begin
            if (wr_w && hit_core) core_control_reg_r <= pwdata[7:0];
            if (wr_w && hit_en)
                irq_enable_control_reg_r <= pwdata[7:0] & epis_pkg::ENABLE_RW_MASK;
        end
    end

    // set wins over clear; level mode forces flag low
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pending_flag_a_r <= 1'b0;
            pending_flag_b_r <= 1'b0;
        end else begin
            pending_flag_a_r <= ~lvl_a & (evt_a | (pending_flag_a_r & ~clr_a));
            pending_flag_b_r <= ~lvl_b & (evt_b | (pending_flag_b_r & ~clr_b));
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    wire [7:0] flag_w = {pending_flag_b_r, pending_flag_a_r, 6'h00};
    wire [7:0] stat_w = {5'h00, startup_busy, low_b, low_a};
    wire [7:0] rd_w   = hit_core ? core_control_reg_r :
                        hit_en   ? irq_enable_control_reg_r :
                        hit_flag ? flag_w :
                        hit_stat ? stat_w : 8'h00;
    always_ff @(posedge sys_clk) begin
        if (reset) prdata_r <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) prdata_r <= {24'h000000, rd_w};
    end
    assign prdata = prdata_r;

    // ****************************************************************
    // requests
    // ****************************************************************
    // level request is raw pin, held while low; no level request during start-up
    assign irq_req_a = en_a & ((lvl_a & low_a & ~startup_busy) | pending_flag_a_r);
    assign irq_req_b = en_b & ((lvl_b & low_b & ~startup_busy) | pending_flag_b_r);
    assign vector_table_select  = irq_enable_control_reg_r[epis_pkg::BIT_VEC_SEL];
    assign vector_change_unlock = irq_enable_control_reg_r[epis_pkg::BIT_VEC_UNLK];
endmodule : epis_top
`default_nettype wire

// [epis_pin_model.sv]
// pin driver model standing for the external sources on both pins
`timescale 1ns/1ps
`default_nettype none
module epis_pin_model (
    // clock
    input  wire logic       sys_clk,
    // requested levels, bit 1 pin b, bit 0 pin a
    input  wire logic [1:0] lvl,
    // pins, pulled up while idle
    output logic            pin_a,
    output logic            pin_b
);
    // ****************************************************************
    // levels move only after an edge and stand whole cycles
    // ****************************************************************
    logic [1:0] pins_r = 2'b11;
    always @(posedge sys_clk) begin
        pins_r <= lvl;
    end
    assign pin_a = pins_r[0];
    assign pin_b = pins_r[1];
endmodule : epis_pin_model
`default_nettype wire

// [epis_top_checker.sv]
// concurrent checks on the pin interrupt sense top ports
`timescale 1ns/1ps
`default_nettype none
module epis_top_checker #(
    parameter int STARTUP_CYC = 4
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // pins and core
    input wire logic        ext_irq_pin_a,
    input wire logic        global_irq_en,
    input wire logic        power_down,
    input wire logic        vec_ack_a,
    // outputs
    input wire logic        irq_req_a,
    input wire logic        irq_req_b,
    input wire logic        wake_req,
    input wire logic        vector_table_select
);
    // ****************************************************************
    // shadow of mode and enables, then the checks
    // ****************************************************************
    wire logic  wr    = psel && penable && pwrite;
    wire logic  wr_en = wr && (paddr == epis_pkg::ADDR_ENABLE);
    wire logic  wr_vs = wr_en && pwdata[1];
    logic [1:0] sa_r;
    logic       ena_r;
    logic       enb_r;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sa_r  <= 2'h0;
            ena_r <= 1'b0;
            enb_r <= 1'b0;
        end else begin
            if (wr && (paddr == epis_pkg::ADDR_CORE_CTRL)) sa_r <= pwdata[1:0];
            if (wr_en) begin
                ena_r <= pwdata[6];
                enb_r <= pwdata[7];
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_GATE_A: assert property (irq_req_a |-> global_irq_en && ena_r)
        else $error("pin a request without both enables");
    AST_GATE_B: assert property (irq_req_b |-> global_irq_en && enb_r)
        else $error("pin b request without both enables");
    AST_LEVEL_HOLD: assert property ((sa_r == 2'h0 && ena_r && global_irq_en
        && !power_down && !ext_irq_pin_a)[*8] |-> irq_req_a) else $error("low level dropped");
    AST_LEVEL_NO_FLAG: assert property ((sa_r == 2'h0 && ext_irq_pin_a)[*4]
        |-> !irq_req_a) else $error("level mode request with pin high");
    AST_ACK_CLEAR: assert property ($stable(ext_irq_pin_a)[*4] ##0
        (vec_ack_a && sa_r != 2'h0) |=> !irq_req_a) else $error("ack left flag set");
    AST_WAKE_PULSE: assert property (wake_req |=> !wake_req)
        else $error("wake longer than one cycle");
    AST_WAKE_IN_PD: assert property (wake_req |-> $past(power_down))
        else $error("wake outside power down");
    AST_VEC_WRITE: assert property ($past(wr_en) |-> vector_table_select == $past(wr_vs))
        else $error("vector select not written");
    AST_UNMAPPED: assert property (psel && penable && paddr > epis_pkg::ADDR_STATUS
        |-> pslverr) else $error("unmapped access not refused");
    cover property (wake_req);
    cover property (vec_ack_a && irq_req_a);
    cover property (irq_req_b);
endmodule : epis_top_checker
bind epis_top epis_top_checker #(.STARTUP_CYC(STARTUP_CYC)) u_epis_top_checker (.sys_clk,
    .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .ext_irq_pin_a,
    .global_irq_en, .power_down, .vec_ack_a, .irq_req_a, .irq_req_b, .wake_req,
    .vector_table_select);
`default_nettype wire

// [test_external_pin_interrupt_sense.sv]
// self-checking bench for the external pin interrupt sense block
`timescale 1ns/1ps
`default_nettype none
module test_external_pin_interrupt_sense;
    // ****************************************************************
    // stimulus, table run and hand tests
    // ****************************************************************
    typedef struct packed {logic b; logic [1:0] mode; logic from; logic to; logic exp;} epis_row_t;
    // b, mode, start level, end level, expected request
    epis_row_t   rows[8] = '{6'h15, 6'h32, 6'h1b, 6'h3c, 6'h0b, 6'h2d, 6'h05, 6'h22};
    epis_row_t   r;
    logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, pin_a, pin_b;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  lvl;
    logic        global_irq_en, io_clk_run, power_down, wdt_tick, vec_ack_a, vec_ack_b;
    logic        irq_req_a, irq_req_b, wake_req, vts, vcu, er, woke;
    int          num_errors = 0;
    int          tests_run = 0;
    epis_pin_model u_epis_pin_model (.sys_clk(sys_clk), .lvl(lvl), .pin_a(pin_a), .pin_b(pin_b));
    epis_top #(.STARTUP_CYC(8)) u_epis_top (.sys_clk(sys_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
        .global_irq_en(global_irq_en), .io_clk_run(io_clk_run), .power_down(power_down),
        .wdt_tick(wdt_tick), .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b),
        .irq_req_a(irq_req_a), .irq_req_b(irq_req_b), .wake_req(wake_req),
        .vector_table_select(vts), .vector_change_unlock(vcu));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // master holds every signal until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // sticky wake seen, one driver only; cleared by reset
    always @(posedge sys_clk) woke <= reset ? 1'b0 : (woke | (wake_req === 1'b1));
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        final_report();
    end
    initial begin
        {reset, global_irq_en, io_clk_run, lvl} = 5'h1f;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {power_down, wdt_tick, vec_ack_a, vec_ack_b} = '0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        apb(1'b1, epis_pkg::ADDR_ENABLE, 32'hc0);
        foreach (rows[i]) begin
            r = rows[i];
            apb(1'b1, epis_pkg::ADDR_CORE_CTRL, {28'h0, r.mode, r.mode});
            lvl <= r.b ? {r.from, 1'b1} : {1'b1, r.from};
            repeat (6) @(posedge sys_clk);
            apb(1'b1, epis_pkg::ADDR_FLAG, 32'hc0);
            lvl <= r.b ? {r.to, 1'b1} : {1'b1, r.to};
            repeat (12) @(negedge sys_clk);
            chk(r.b ? irq_req_b : irq_req_a, r.exp);
            apb(1'b0, epis_pkg::ADDR_FLAG, 32'h0);
            chk(rd, (r.exp && r.mode != 2'h0) ? (r.b ? 32'h80 : 32'h40) : 32'h0);
        end
        // second reset mid-run, then register access kinds
        reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        apb(1'b0, epis_pkg::ADDR_ENABLE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, epis_pkg::ADDR_ENABLE, 32'hffffffff);
        apb(1'b0, epis_pkg::ADDR_ENABLE, 32'h0);
        chk(rd, 32'hc3);
        chk(vts, 1'b1);
        chk(vcu, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        // falling edge held back by the global enable
        apb(1'b1, epis_pkg::ADDR_CORE_CTRL, 32'ha);
        global_irq_en <= 1'b0;
        lvl <= 2'b00;
        repeat (8) @(negedge sys_clk);
        chk(irq_req_a, 1'b0);
        apb(1'b1, epis_pkg::ADDR_FLAG, 32'h0);
        apb(1'b0, epis_pkg::ADDR_FLAG, 32'h0);
        chk(rd, 32'hc0);
        global_irq_en <= 1'b1;
        @(negedge sys_clk);
        chk(irq_req_a, 1'b1);
        chk(irq_req_b, 1'b1);
        @(posedge sys_clk);
        {vec_ack_a, vec_ack_b} <= 2'b11;
        @(posedge sys_clk);
        {vec_ack_a, vec_ack_b} <= 2'b00;
        @(negedge sys_clk);
        chk(irq_req_a, 1'b0);
        chk(irq_req_b, 1'b0);
        // power-down wake by low level that leaves before start-up ends
        apb(1'b1, epis_pkg::ADDR_CORE_CTRL, 32'h0);
        apb(1'b0, epis_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h3);
        lvl <= 2'b11;
        {power_down, io_clk_run} <= 2'b10;
        @(posedge sys_clk);
        lvl <= 2'b10;
        repeat (2) begin
            repeat (199) @(posedge sys_clk);
            wdt_tick <= 1'b1;
            @(posedge sys_clk);
            wdt_tick <= 1'b0;
        end
        repeat (2) @(posedge sys_clk);
        chk(woke, 1'b1);
        lvl <= 2'b11;
        {power_down, io_clk_run} <= 2'b01;
        repeat (10) begin
            @(negedge sys_clk);
            chk(irq_req_a, 1'b0);
        end
        final_report();
    end
endmodule : test_external_pin_interrupt_sense
`default_nettype wire
